// [design/i2cas_core.sv]
`timescale 1ns/10ps
module i2cas_core
    import i2cas_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial pins, open drain
    input wire logic sclIn,
    output logic sclOut,
    output logic sclOe,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // Interrupt
    output logic irq
);

    // ************************************************************
    // Address decode
    // ************************************************************
    function automatic logic isIdx(input logic [APB_AW-1:0] addr, input logic [7:0] idx);
        isIdx = (addr[11:10] == 2'h0) && (addr[1:0] == 2'h0) && (addr[9:2] == idx);
    endfunction

    wire logic setupRd = psel && !penable && !pwrite;
    wire logic access = psel && penable;
    wire logic hitBuf = isIdx(paddr, IDX_BUF);
    wire logic hitState = isIdx(paddr, IDX_STATE);
    wire logic hitCtrl = isIdx(paddr, IDX_CTRL);
    wire logic hitOwn = isIdx(paddr, IDX_OWN);
    wire logic hitIrq = isIdx(paddr, IDX_IRQ);
    wire logic hitMask = isIdx(paddr, IDX_MASK);
    wire logic hitAny = hitBuf || hitState || hitCtrl || hitOwn || hitIrq || hitMask;
    wire logic wrAcc = access && pwrite;
    wire logic wrBuf = wrAcc && hitBuf;
    wire logic wrCtrl = wrAcc && hitCtrl;
    wire logic wrOwn = wrAcc && hitOwn;
    wire logic wrIrq = wrAcc && hitIrq;
    wire logic wrMask = wrAcc && hitMask;

    // ************************************************************
    // Registers and state
    // ************************************************************
    i2cas_line_t lineNow;
    i2cas_line_t linePrev;
    i2cas_state_t state;
    i2cas_state_t next_state;
    logic [7:0] byteBuf;
    logic [4:0] code;
    logic si;
    logic ackAssert;
    logic [7:0] ownAddr;
    logic [1:0] irqStatus;
    logic [1:0] irqMask;
    logic [3:0] bitCnt;
    logic [3:0] next_bitCnt;
    logic addrPhase;
    logic next_addrPhase;
    logic txMode;
    logic next_txMode;
    logic gcMode;
    logic next_gcMode;
    logic ackDrive;
    logic next_ackDrive;
    logic masterAck;
    logic next_masterAck;
    logic txBit;
    logic evSet;
    logic [7:0] evCode;
    logic detach;

    i2cas_line_sync u_sync (
        .clk(clk),
        .rst(rst),
        .sclIn(sclIn),
        .sdaIn(sdaIn),
        .lineNow(lineNow),
        .linePrev(linePrev)
    );

    // ************************************************************
    // Bus conditions
    // ************************************************************
    wire logic sclRise = lineNow.scl && !linePrev.scl;
    wire logic sclFall = !lineNow.scl && linePrev.scl;
    wire logic startDet = lineNow.scl && linePrev.scl && linePrev.sda && !lineNow.sda;
    wire logic stopDet = lineNow.scl && linePrev.scl && !linePrev.sda && lineNow.sda;
    wire logic frameEdge = startDet || stopDet;
    wire logic gcHit = ownAddr[OWN_GC_BIT] && (byteBuf == 8'h00);
    wire logic ownHit = byteBuf[7:1] == ownAddr[7:1];
    wire logic addrMatch = ackAssert && (ownHit || gcHit);
    wire logic hwShift = (state == ST_BYTE) && sclRise && !si && (bitCnt < BIT_LAST) && !frameEdge;
    wire logic [7:0] statusByte = {code, 3'h0};
    wire logic [7:0] ctrlByte = {4'h0, si, ackAssert, 2'h0};
    wire logic [31:0] readMux = hitBuf ? {24'h0, byteBuf} :
                                hitState ? {24'h0, statusByte} :
                                hitCtrl ? {24'h0, ctrlByte} :
                                hitOwn ? {24'h0, ownAddr} :
                                hitIrq ? {30'h0, irqStatus} :
                                hitMask ? {30'h0, irqMask} : 32'h0;

    // ************************************************************
    // Transfer sequencing
    // ************************************************************
    always_comb begin
        next_state = state;
        next_bitCnt = bitCnt;
        next_addrPhase = addrPhase;
        next_txMode = txMode;
        next_gcMode = gcMode;
        next_ackDrive = ackDrive;
        next_masterAck = masterAck;
        evSet = 1'b0;
        evCode = CODE_NONE;
        detach = 1'b0;
        if (frameEdge) begin
            if ((state != ST_IDLE) && !addrPhase) begin
                evSet = 1'b1;
                evCode = CODE_STOP;
            end
            next_state = startDet ? ST_BYTE : ST_IDLE;
            next_bitCnt = 4'h0;
            next_addrPhase = 1'b1;
            next_txMode = 1'b0;
        end else if (!si) begin
            case (state)
                ST_BYTE: begin
                    if (sclRise && (bitCnt < BIT_LAST)) begin
                        next_bitCnt = 4'(bitCnt + 4'h1);
                    end else if (sclFall && (bitCnt == BIT_LAST)) begin
                        if (addrPhase) begin
                            // Silent drop, no code, no flag
                            next_state = addrMatch ? ST_ACK : ST_IDLE;
                            next_ackDrive = 1'b1;
                            next_gcMode = gcHit;
                        end else begin
                            // Receive: ack level; transmit: keep-going flag
                            next_state = ST_ACK;
                            next_ackDrive = ackAssert;
                        end
                    end
                end
                ST_ACK: begin
                    if (sclRise) begin
                        next_masterAck = !lineNow.sda;
                    end else if (sclFall) begin
                        evSet = 1'b1;
                        next_bitCnt = 4'h0;
                        next_state = ST_BYTE;
                        next_addrPhase = 1'b0;
                        if (addrPhase) begin
                            evCode = gcMode ? CODE_GC : (byteBuf[0] ? CODE_SLA_R : CODE_SLA_W);
                            next_txMode = byteBuf[0] && !gcMode;
                        end else if (!txMode) begin
                            if (ackDrive) begin
                                evCode = gcMode ? CODE_GC_ACK : CODE_RX_ACK;
                            end else begin
                                evCode = gcMode ? CODE_GC_NACK : CODE_RX_NACK;
                                next_state = ST_IDLE;
                                detach = 1'b1;
                            end
                        end else if (!masterAck) begin
                            evCode = CODE_TX_NACK;
                            next_state = ST_IDLE;
                            detach = 1'b1;
                        end else if (!ackDrive) begin
                            evCode = CODE_TX_LAST;
                            next_state = ST_IDLE;
                            detach = 1'b1;
                        end else begin
                            evCode = CODE_TX_ACK;
                        end
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
            bitCnt <= 4'h0;
            addrPhase <= 1'b1;
            txMode <= 1'b0;
            gcMode <= 1'b0;
            ackDrive <= 1'b0;
            masterAck <= 1'b0;
        end else begin
            state <= next_state;
            bitCnt <= next_bitCnt;
            addrPhase <= next_addrPhase;
            txMode <= next_txMode;
            gcMode <= next_gcMode;
            ackDrive <= next_ackDrive;
            masterAck <= next_masterAck;
        end
    end

    // ************************************************************
    // Event flag and state code
    // ************************************************************
    // Hardware set wins over a same-cycle software clear
    wire logic siClr = wrCtrl && !pwdata[CTRL_SI_BIT];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            si <= 1'b0;
            code <= CODE_NONE[7:3];
        end else if (evSet) begin
            si <= 1'b1;
            code <= evCode[7:3];
        end else if (siClr) begin
            si <= 1'b0;
            code <= CODE_NONE[7:3];
        end
    end

    // ************************************************************
    // Byte buffer and transmit bit
    // ************************************************************
    // Shifting in on every bit keeps the bus byte, even when another master won
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            byteBuf <= BUF_RST;
        end else if (hwShift) begin
            byteBuf <= {byteBuf[6:0], lineNow.sda};
        end else if (wrBuf) begin
            byteBuf <= pwdata[7:0];
        end
    end

    // Next bit changes only while SCL is low
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            txBit <= 1'b1;
        end else if (si || ((state == ST_BYTE) && sclFall)) begin
            txBit <= byteBuf[7];
        end
    end

    // ************************************************************
    // Software registers and interrupt
    // ************************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ackAssert <= CTRL_ACK_RST;
            ownAddr <= OWN_RST;
            irqMask <= IRQ_RST;
        end else begin
            if (wrCtrl) ackAssert <= pwdata[CTRL_ACK_BIT];
            if (wrOwn) ownAddr <= pwdata[7:0];
            if (wrMask) irqMask <= pwdata[1:0];
        end
    end

    wire logic [1:0] irqSet = {detach, evSet};
    wire logic [1:0] irqClr = wrIrq ? pwdata[1:0] : 2'h0;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irqStatus <= IRQ_RST;
        end else begin
            irqStatus <= (irqStatus & ~irqClr) | irqSet;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0;
        end else if (setupRd) begin
            prdata <= readMux;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign pready = 1'b1;
    assign pslverr = access && !hitAny;
    assign irq = |(irqStatus & irqMask);
    assign sclOut = 1'b0;
    assign sclOe = si;
    assign sdaOut = 1'b0;
    // Idle drives nothing on SDA, so a detached slave reads as all ones
    assign sdaOe = ((state == ST_ACK) && ackDrive && !txMode) ||
                   ((state == ST_BYTE) && txMode && !addrPhase && !txBit);

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_addrDecide;
        (state == ST_BYTE) && addrPhase && sclFall && (bitCnt == BIT_LAST) && !si && !frameEdge;
    endsequence

    sequence s_ackEnd;
        (state == ST_ACK) && sclFall && !si && !frameEdge;
    endsequence

    chk_none_flag_low: assert property ((code == CODE_NONE[7:3]) |-> !si)
        else $error("no-info code shown with event flag set");

    chk_event_code: assert property ($rose(si) |-> (code != CODE_NONE[7:3]) && irqStatus[IRQ_EVENT_BIT])
        else $error("event flag rose without a state code");

    chk_stretch_scl: assert property ((si && !frameEdge) |-> sclOe && !sclOut &&
                                      (next_state == state) && (next_bitCnt == bitCnt))
        else $error("SCL not held low while flag set");

    chk_buf_frozen: assert property ((si && $past(si) && !$past(wrBuf)) |-> $stable(byteBuf))
        else $error("byte buffer changed while flag set");

    chk_ack_low: assert property (((state == ST_ACK) && ackDrive && !txMode) |-> sdaOe)
        else $error("acknowledge not driven");

    chk_nack_high: assert property (((state == ST_ACK) && !ackDrive) |-> !sdaOe)
        else $error("SDA driven during a not-acknowledge");

    chk_ignore_address: assert property ((s_addrDecide ##0 !ackAssert) |=> (state == ST_IDLE) && !si)
        else $error("address taken with ack flag clear");

    chk_rx_fallback: assert property ((s_ackEnd ##0 (!addrPhase && !txMode && !ackDrive)) |=>
                                      (state == ST_IDLE) && si && ((statusByte | 8'h10) == CODE_GC_NACK))
        else $error("slave stayed addressed after not-acknowledge");

    chk_last_detach: assert property ((s_ackEnd ##0 (txMode && !addrPhase && masterAck && !ackDrive)) |=>
                                      (statusByte == CODE_TX_LAST) && (state == ST_IDLE))
        else $error("last byte did not detach with C8H");

    chk_idle_release: assert property ((state == ST_IDLE) |-> !sdaOe)
        else $error("detached slave drives SDA");

    chk_status_read: assert property ((setupRd && hitState) |=>
                                      (prdata[2:0] == 3'h0) && (prdata[7:3] == $past(code)))
        else $error("status read returns wrong layout");

    chk_shift_in: assert property (hwShift |=> (byteBuf[0] == $past(lineNow.sda)))
        else $error("bus bit not shifted into buffer");

endmodule

// [design/i2cas_pkg.sv]
package i2cas_pkg;

    // ************************************************************
    // Register map (indices, byte address is four times the index)
    // ************************************************************
    localparam int APB_AW = 12;
    localparam logic [7:0] IDX_BUF = 8'hBC;
    localparam logic [7:0] IDX_STATE = 8'hBD;
    localparam logic [7:0] IDX_CTRL = 8'hC0;
    localparam logic [7:0] IDX_OWN = 8'hC1;
    localparam logic [7:0] IDX_IRQ = 8'hC2;
    localparam logic [7:0] IDX_MASK = 8'hC3;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int CTRL_ACK_BIT = 2;
    localparam int CTRL_SI_BIT = 3;
    localparam int OWN_GC_BIT = 0;
    localparam int IRQ_EVENT_BIT = 0;
    localparam int IRQ_DETACH_BIT = 1;
    localparam logic [7:0] BUF_RST = 8'h00;
    localparam logic [7:0] OWN_RST = 8'h00;
    localparam logic CTRL_ACK_RST = 1'b0;
    localparam logic [1:0] IRQ_RST = 2'h0;
    localparam logic [3:0] BIT_LAST = 4'h8;

    // ************************************************************
    // Bus state codes
    // ************************************************************
    localparam logic [7:0] CODE_NONE = 8'hF8;
    localparam logic [7:0] CODE_SLA_W = 8'h60;
    localparam logic [7:0] CODE_GC = 8'h70;
    localparam logic [7:0] CODE_RX_ACK = 8'h80;
    localparam logic [7:0] CODE_RX_NACK = 8'h88;
    localparam logic [7:0] CODE_GC_ACK = 8'h90;
    localparam logic [7:0] CODE_GC_NACK = 8'h98;
    localparam logic [7:0] CODE_STOP = 8'hA0;
    localparam logic [7:0] CODE_SLA_R = 8'hA8;
    localparam logic [7:0] CODE_TX_ACK = 8'hB8;
    localparam logic [7:0] CODE_TX_NACK = 8'hC0;
    localparam logic [7:0] CODE_TX_LAST = 8'hC8;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_BYTE = 3'b010,
        ST_ACK = 3'b100
    } i2cas_state_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } i2cas_line_t;

endpackage

// [design/i2cas_line_sync.sv]
`timescale 1ns/10ps
module i2cas_line_sync
    import i2cas_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Raw pins
    input wire logic sclIn,
    input wire logic sdaIn,
    // Synchronised line, current and one cycle older
    output i2cas_line_t lineNow,
    output i2cas_line_t linePrev
);

    // Idle bus is high, so all stages reset high
    i2cas_line_t meta;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta <= 2'h3;
            lineNow <= 2'h3;
            linePrev <= 2'h3;
        end else begin
            meta <= '{scl: sclIn, sda: sdaIn};
            lineNow <= meta;
            linePrev <= lineNow;
        end
    end

endmodule

// [verif/i2cas_bus_master.sv]
`timescale 1ns/10ps
// ********************
// Bus master model
// ********************
module i2cas_bus_master
(
    // Clock
    input wire logic clk,
    // Resolved bus lines
    input wire logic sclLine,
    input wire logic sdaLine,
    // Pull-downs, high pulls the line low
    output logic sclPull,
    output logic sdaPull
);
    localparam int HALF = 8;

    initial begin
        sclPull = 1'b0;
        sdaPull = 1'b0;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Stretching: wait for the line, not for our own release
    task automatic waitHigh();
        do @(posedge clk); while (sclLine !== 1'b1);
    endtask

    task automatic pulse(output logic smp);
        sclPull <= 1'b0;
        waitHigh();
        hold(HALF / 2);
        smp = sdaLine;
        hold(HALF / 2);
        sclPull <= 1'b1;
        hold(2);
    endtask

    task automatic start();
        sdaPull <= 1'b1;
        hold(HALF);
        sclPull <= 1'b1;
        hold(HALF);
    endtask

    task automatic stop();
        sdaPull <= 1'b1;
        hold(HALF);
        sclPull <= 1'b0;
        waitHigh();
        hold(HALF);
        sdaPull <= 1'b0;
        hold(HALF);
    endtask

    task automatic wrByte(input logic [7:0] d, output logic nack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            sdaPull <= ~d[i];
            hold(HALF);
            pulse(s);
        end
        sdaPull <= 1'b0;
        hold(HALF);
        pulse(nack);
    endtask

    // Clash bits pull SDA low against the slave on purpose
    task automatic rdByte(input logic ack, input logic [7:0] clash, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            sdaPull <= clash[i];
            hold(HALF);
            pulse(s);
            d[i] = s;
        end
        sdaPull <= ack;
        hold(HALF);
        pulse(s);
        sdaPull <= 1'b0;
        hold(2);
    endtask
endmodule

// [verif/i2c_ack_status_data_test.sv]
`timescale 1ns/10ps
`define CHK(got, exp) check(32'(got), 32'(exp))
module i2c_ack_status_data_test
    import i2cas_pkg::*;
;
    localparam int LIMIT = 20000;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, errBit;
    logic [APB_AW-1:0] paddr;
    logic [31:0] pwdata, prdata, rdData;
    logic sclOut, sclOe, sdaOut, sdaOe, irq, mScl, mSda, ackBit, sclLine, sdaLine;
    logic [7:0] rx;
    int failCount = 0;
    int compares = 0;
    int cycles = 0;

    // Open drain: any pull wins over the pull-up
    assign sclLine = !(sclOe | mScl);
    assign sdaLine = !(sdaOe | mSda);

    i2cas_core i_i2cas_core (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sclIn(sclLine), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaLine), .sdaOut(sdaOut),
        .sdaOe(sdaOe), .irq(irq));
    i2cas_bus_master i_i2cas_bus_master (.clk(clk), .sclLine(sclLine), .sdaLine(sdaLine),
        .sclPull(mScl), .sdaPull(mSda));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ********************
    // Shared tasks
    // ********************
    function automatic logic [11:0] regAddr(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failCount++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic endSim();
        $display("compares=%0d failCount=%0d", compares, failCount);
        if (failCount == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [11:0] addr, input logic [7:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= {24'h000000, wd};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdData = prdata;
        errBit = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdChk(input logic [7:0] idx, input logic [7:0] exp);
        apb(1'b0, regAddr(idx), 8'h00);
        `CHK(rdData, {24'h000000, exp});
    endtask

    // Bounded wait for the held clock, then the code
    task automatic evt(input logic [7:0] code);
        int n;
        n = 0;
        while (sclOe !== 1'b1 && n < 40) begin
            @(posedge clk);
            n++;
        end
        `CHK(sclOe, 1'b1);
        rdChk(IDX_STATE, code);
    endtask

    // One more edge so the cleared bits have landed before anyone looks
    task automatic clr(input logic [7:0] ctl);
        apb(1'b1, regAddr(IDX_CTRL), ctl);
        apb(1'b1, regAddr(IDX_IRQ), 8'h03);
        @(posedge clk);
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            failCount++;
            endSim();
        end
    end

    // ********************
    // Tests
    // ********************
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rdChk(IDX_STATE, CODE_NONE);
        `CHK(errBit, 1'b0);
        rdChk(IDX_BUF, BUF_RST);
        `CHK({sclOe, sdaOe, irq, sclOut, sdaOut}, 5'h00);
        apb(1'b0, 12'h000, 8'h00);
        `CHK(errBit, 1'b1);
        apb(1'b1, regAddr(IDX_MASK), 8'h03);
        apb(1'b1, regAddr(IDX_OWN), 8'hA0);
        $display("test reset done");

        i_i2cas_bus_master.start();
        i_i2cas_bus_master.wrByte(8'hA0, ackBit);
        `CHK(ackBit, 1'b1);
        repeat (40) @(posedge clk);
        rdChk(IDX_STATE, CODE_NONE);
        `CHK(irq, 1'b0);
        i_i2cas_bus_master.stop();
        $display("test ignored done");

        apb(1'b1, regAddr(IDX_CTRL), 8'h0C);
        i_i2cas_bus_master.start();
        i_i2cas_bus_master.wrByte(8'hA0, ackBit);
        `CHK(ackBit, 1'b0);
        evt(CODE_SLA_W);
        `CHK({irq, sclOe}, 2'b11);
        rdChk(IDX_BUF, 8'hA0);
        clr(8'h04);
        `CHK({irq, sclOe}, 2'b00);
        i_i2cas_bus_master.wrByte(8'h3C, ackBit);
        `CHK(ackBit, 1'b0);
        evt(CODE_RX_ACK);
        repeat (30) @(posedge clk);
        rdChk(IDX_BUF, 8'h3C);
        apb(1'b1, regAddr(IDX_CTRL), 8'h08);
        rdChk(IDX_STATE, CODE_RX_ACK);
        clr(8'h00);
        i_i2cas_bus_master.wrByte(8'h55, ackBit);
        `CHK(ackBit, 1'b1);
        evt(CODE_RX_NACK);
        rdChk(IDX_IRQ, 8'h03);
        // Flag back on, but no new address: still deaf
        clr(8'h04);
        i_i2cas_bus_master.wrByte(8'h66, ackBit);
        `CHK(ackBit, 1'b1);
        repeat (40) @(posedge clk);
        rdChk(IDX_STATE, CODE_NONE);
        i_i2cas_bus_master.stop();
        $display("test receive done");

        apb(1'b1, regAddr(IDX_OWN), 8'hA1);
        i_i2cas_bus_master.start();
        i_i2cas_bus_master.wrByte(8'h00, ackBit);
        `CHK(ackBit, 1'b0);
        evt(CODE_GC);
        clr(8'h04);
        i_i2cas_bus_master.wrByte(8'h12, ackBit);
        `CHK(ackBit, 1'b0);
        evt(CODE_GC_ACK);
        rdChk(IDX_BUF, 8'h12);
        clr(8'h04);
        i_i2cas_bus_master.stop();
        evt(CODE_STOP);
        clr(8'h04);
        $display("test general call done");

        i_i2cas_bus_master.start();
        i_i2cas_bus_master.wrByte(8'hA1, ackBit);
        evt(CODE_SLA_R);
        apb(1'b1, regAddr(IDX_BUF), 8'hC3);
        clr(8'h04);
        i_i2cas_bus_master.rdByte(1'b1, 8'h01, rx);
        `CHK(rx, 8'hC2);
        evt(CODE_TX_ACK);
        rdChk(IDX_BUF, 8'hC2);
        apb(1'b1, regAddr(IDX_BUF), 8'h96);
        clr(8'h04);
        // Master refuses the byte: slave must let go
        i_i2cas_bus_master.rdByte(1'b0, 8'h00, rx);
        `CHK(rx, 8'h96);
        evt(CODE_TX_NACK);
        rdChk(IDX_IRQ, 8'h03);
        clr(8'h04);
        i_i2cas_bus_master.stop();
        i_i2cas_bus_master.start();
        i_i2cas_bus_master.wrByte(8'hA1, ackBit);
        `CHK(ackBit, 1'b0);
        evt(CODE_SLA_R);
        apb(1'b1, regAddr(IDX_BUF), 8'h5A);
        clr(8'h00);
        i_i2cas_bus_master.rdByte(1'b1, 8'h00, rx);
        `CHK(rx, 8'h5A);
        evt(CODE_TX_LAST);
        rdChk(IDX_IRQ, 8'h03);
        clr(8'h00);
        i_i2cas_bus_master.rdByte(1'b0, 8'h00, rx);
        `CHK(rx, 8'hFF);
        i_i2cas_bus_master.stop();
        repeat (40) @(posedge clk);
        rdChk(IDX_STATE, CODE_NONE);
        $display("test transmit done");
        endSim();
    end
endmodule
